/* File: verilog/tw_defines.svh */
// Register indices, field positions, reset values and timing figures of the two-wire master.
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH
`define TW_IDX_DATA 8'h0A
`define TW_IDX_CMD 8'h0B
`define TW_IDX_CTRL 8'h0C
`define TW_CTRL_SPEED_LO 0
`define TW_CTRL_EN 2
`define TW_CTRL_SEL0 4
`define TW_CTRL_SEL1 5
`define TW_CTRL_HALF 7
`define TW_CTRL_WMASK 8'hBF
`define TW_CTRL_RD_ONES 8'h40
`define TW_CTRL_RESET 8'h00
`define TW_CMD_LO 4
`define TW_CMD_RST 1
`define TW_CMD_BUSY 0
`define TW_CMD_RD_ONES 8'hFE
`define TW_DATA_MACK 7
`define TW_DATA_SACK 0
`define TW_DATA_RESET 8'h00
`define TW_NB_FULL 4'h9
`define TW_NB_BYTE 4'h8
`define TW_NB_ONE 4'h1
`define TW_MCLK_KHZ 100000
`define TW_RATE0_KHZ 10
`define TW_RATE1_KHZ 50
`define TW_RATE2_KHZ 100
`define TW_RATE3_KHZ 330
`define TW_QUARTERS 4
`define TW_FILT_LEN 3
`endif

/* File: verilog/tw_pkg.sv */
// Types shared by the two-wire master, its checker and its bench.
package tw_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } tw_pair_t;

  typedef enum logic [2:0] {
    TW_OP_ADDR = 3'h0,
    TW_OP_WRITE = 3'h1,
    TW_OP_ACK_RX = 3'h2,
    TW_OP_ACK = 3'h3,
    TW_OP_NULL0 = 3'h4,
    TW_OP_NULL1 = 3'h5,
    TW_OP_RX_FIRST = 3'h6,
    TW_OP_STOP = 3'h7
  } tw_cmd_t;

  typedef enum logic [1:0] {
    TW_IDLE,
    TW_START,
    TW_BIT,
    TW_STOP
  } tw_state_t;
endpackage : tw_pkg

/* File: verilog/tw_glitch_filter.sv */
// Synchroniser and glitch filter for the four bus input pins.
`timescale 1ns/1ps
`include "tw_defines.svh"
module tw_glitch_filter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] raw,
  output logic [3:0] clean
);
  logic [3:0] meta;
  logic [3:0] sync;
  logic [3:0] hist [`TW_FILT_LEN];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta <= 4'hF;
      sync <= 4'hF;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // A level passes only after it has stood for the whole filter length.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `TW_FILT_LEN; i++) begin
        hist[i] <= 4'hF;
      end
      clean <= 4'hF;
    end else begin
      hist[0] <= sync;
      for (int i = 1; i < `TW_FILT_LEN; i++) begin
        hist[i] <= hist[i-1];
      end
      for (int b = 0; b < 4; b++) begin
        if (hist[0][b] == hist[1][b] && hist[1][b] == hist[2][b]) begin
          clean[b] <= hist[0][b];
        end
      end
    end
  end
endmodule : tw_glitch_filter

/* File: verilog/tw_tick_gen.sv */
// Quarter-bit tick generator for the selected bus rate.
`timescale 1ns/1ps
`include "tw_defines.svh"
module tw_tick_gen (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [1:0] speed,
  input wire logic half_clk,
  output logic tick
);
  logic [12:0] cnt;
  logic [12:0] lim;

  function automatic logic [12:0] tw_quarter(input logic [1:0] sp, input logic half);
    int q;
    q = 0;
    unique case (sp)
      2'h0: q = `TW_MCLK_KHZ / (`TW_QUARTERS * `TW_RATE0_KHZ);
      2'h1: q = `TW_MCLK_KHZ / (`TW_QUARTERS * `TW_RATE1_KHZ);
      2'h2: q = `TW_MCLK_KHZ / (`TW_QUARTERS * `TW_RATE2_KHZ);
      2'h3: q = `TW_MCLK_KHZ / (`TW_QUARTERS * `TW_RATE3_KHZ);
    endcase
    // The half-rate clock option stretches every quarter to twice its length.
    if (half) begin
      q = q * 2;
    end
    return 13'(q);
  endfunction : tw_quarter

  assign lim = tw_quarter(speed, half_clk); // RL2 RL10

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 13'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 13'h0000;
      tick <= 1'b0;
    end else if (cnt >= lim - 13'h0001) begin
      cnt <= 13'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 13'h0001;
      tick <= 1'b0;
    end
  end
endmodule : tw_tick_gen

/* File: verilog/tw_master.sv */
// Single-master two-wire bus controller with an AHB-Lite register port.
// Contract
// RL1 - Sole bus master; no arbitration logic of any kind.
// RL2 - Control bits 1:0 pick 10, 50, 100 or 330 kHz.
// RL3 - Both bus inputs pass a three-period digital glitch filter.
// RL4 - Two pin pairs share one state machine; one pair active.
// RL5 - Control bit 2 enables the interface; zero holds it inactive.
// RL6 - Software presets the pair's port data bits to one first.
// RL7 - Pins assigned to the bus switch to open-drain drive.
// RL8 - Software sets bus pins as outputs while enabled.
// RL9 - Software keeps standard drive strength while the bus runs.
// RL10 - Control bit 7 selects full or half interface clock.
// RL11 - Control bit 5 routes pair one onto its port pins.
// RL12 - Control bit 4 routes pair zero onto its port pins.
// RL13 - With both select bits set, pair zero wins.
// RL14 - Command in bits 6:4, bit 1 resets, bit 0 reads busy.
// RL15 - Data register: transmit byte, received byte, master and slave acknowledge.
// RL16 - Command 000: start, address byte, slave acknowledge, nine clocks.
// RL17 - Command 001: data byte, slave acknowledge, nine clocks.
// RL18 - Command 010: master acknowledge then receive byte, nine clocks.
// RL19 - Command 011: master acknowledge only, one clock.
// RL20 - Commands 10X do nothing and go only with reset.
// RL21 - Command 110: receive first byte, eight clocks.
// RL22 - Command 111: stop condition, one clock.
// RL23 - Busy rises on command write, clears after its last clock.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tw_defines.svh"
module tw_master (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire tw_pkg::tw_pair_t pair0_in,
  output tw_pkg::tw_pair_t pair0_out,
  output tw_pkg::tw_pair_t pair0_oe,
  output logic pair0_owned,
  input wire tw_pkg::tw_pair_t pair1_in,
  output tw_pkg::tw_pair_t pair1_out,
  output tw_pkg::tw_pair_t pair1_oe,
  output logic pair1_owned
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl;
  logic [7:0] data;
  logic busy;
  tw_pkg::tw_cmd_t cmd;
  tw_pkg::tw_state_t state;
  logic [1:0] quarter;
  logic [3:0] idx;
  logic scl_low;
  logic sda_low;
  logic ap_wr;
  logic ap_rd;
  logic [7:0] ap_addr;
  logic rd_wait;
  logic [3:0] filt;
  logic tick;
  logic en;
  logic use_p1;
  logic act0;
  logic act1;
  logic scl_f;
  logic sda_f;
  logic wr_data;
  logic wr_cmd;
  logic wr_ctrl;
  logic soft_rst;
  logic start_cmd;
  tw_pkg::tw_cmd_t new_cmd;
  logic bit_rx;
  logic bit_val;
  logic last_bit;
  logic adv;

  function automatic logic tw_hit(input logic [7:0] addr, input logic [7:0] index);
    return addr == 8'({index[5:0], 2'h0});
  endfunction : tw_hit

  // A transfer is asked for when the slave is selected and the phase is neither idle nor busy.
  function automatic logic tw_take(input logic sel, input logic [1:0] trans);
    return sel & trans[1];
  endfunction : tw_take

  // Null codes count one pulse so the bit counter stays in range; they never run.
  function automatic logic [3:0] tw_nbits(input tw_pkg::tw_cmd_t c);
    logic [3:0] n;
    n = `TW_NB_ONE;
    unique case (c)
      tw_pkg::TW_OP_ADDR, tw_pkg::TW_OP_WRITE, tw_pkg::TW_OP_ACK_RX: n = `TW_NB_FULL;
      tw_pkg::TW_OP_RX_FIRST: n = `TW_NB_BYTE;
      tw_pkg::TW_OP_ACK, tw_pkg::TW_OP_STOP: n = `TW_NB_ONE;
      tw_pkg::TW_OP_NULL0, tw_pkg::TW_OP_NULL1: n = `TW_NB_ONE;
    endcase
    return n;
  endfunction : tw_nbits

  // Tells which bits of a command the master receives rather than drives.
  function automatic logic tw_is_rx(input tw_pkg::tw_cmd_t c, input logic [3:0] i);
    logic r;
    r = 1'b0;
    unique case (c)
      tw_pkg::TW_OP_ADDR, tw_pkg::TW_OP_WRITE: r = (i == `TW_NB_BYTE);
      tw_pkg::TW_OP_ACK_RX: r = (i != 4'h0);
      tw_pkg::TW_OP_RX_FIRST: r = 1'b1;
      tw_pkg::TW_OP_ACK, tw_pkg::TW_OP_STOP: r = 1'b0;
      tw_pkg::TW_OP_NULL0, tw_pkg::TW_OP_NULL1: r = 1'b0;
    endcase
    return r;
  endfunction : tw_is_rx

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: input filtering and the bus-rate tick.
  tw_glitch_filter tw_glitch_filter_inst (
    .mclk(mclk),
    .rstn(rstn),
    .raw({pair1_in.scl, pair1_in.sda, pair0_in.scl, pair0_in.sda}),
    .clean(filt)
  ); // RL3

  // The tick only runs while busy, so every command starts on a whole quarter.
  tw_tick_gen tw_tick_gen_inst (
    .mclk(mclk),
    .rstn(rstn),
    .run(busy),
    .speed(ctrl[`TW_CTRL_SPEED_LO +: 2]),
    .half_clk(ctrl[`TW_CTRL_HALF]),
    .tick(tick)
  ); // RL2 RL10

  assign en = ctrl[`TW_CTRL_EN];
  assign act0 = ctrl[`TW_CTRL_SEL0]; // RL12
  assign use_p1 = ctrl[`TW_CTRL_SEL1] & ~ctrl[`TW_CTRL_SEL0]; // RL11 RL13
  assign act1 = use_p1;
  // One state machine serves whichever pair is routed.
  assign scl_f = use_p1 ? filt[3] : filt[1]; // RL4
  assign sda_f = use_p1 ? filt[2] : filt[0]; // RL4

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait state, reads take one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr <= tw_take(hsel, htrans) & hwrite & (hsize == 3'h2);
      ap_rd <= tw_take(hsel, htrans) & ~hwrite & (hsize == 3'h2);
      ap_addr <= haddr[7:0];
    end else begin
      ap_rd <= 1'b0;
    end
  end

  // Reads wait one cycle so that a write just before them is already stored.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_wait <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready && tw_take(hsel, htrans) && !hwrite) begin
        rd_wait <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_wait) begin
        rd_wait <= 1'b0;
        hreadyout <= 1'b1;
        // Unmapped and odd-sized reads return zero with an OKAY response.
        if (!ap_rd) begin
          hrdata <= 32'h0000_0000;
        end else if (tw_hit(ap_addr, `TW_IDX_DATA)) begin
          hrdata <= {24'h000000, data}; // RL15
        end else if (tw_hit(ap_addr, `TW_IDX_CMD)) begin
          hrdata <= {24'h000000, `TW_CMD_RD_ONES | {7'h00, busy}}; // RL14
        end else if (tw_hit(ap_addr, `TW_IDX_CTRL)) begin
          hrdata <= {24'h000000, (ctrl & `TW_CTRL_WMASK) | `TW_CTRL_RD_ONES};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  assign wr_data = ap_wr & tw_hit(ap_addr, `TW_IDX_DATA);
  assign wr_cmd = ap_wr & tw_hit(ap_addr, `TW_IDX_CMD);
  assign wr_ctrl = ap_wr & tw_hit(ap_addr, `TW_IDX_CTRL);
  assign soft_rst = wr_cmd & hwdata[`TW_CMD_RST]; // RL14
  assign new_cmd = tw_pkg::tw_cmd_t'(hwdata[`TW_CMD_LO +: 3]);
  // Null codes never start a transfer, with or without the reset bit.
  assign start_cmd = wr_cmd & ~soft_rst & en & ~busy & (new_cmd[2:1] != 2'h2); // RL20

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `TW_CTRL_RESET;
    end else if (wr_ctrl) begin
      // Bit six is not stored; it always reads back as one.
      ctrl <= hwdata[7:0] & `TW_CTRL_WMASK; // RL5 RL10 RL11 RL12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit sequencer. Each bus bit is four quarters; the high quarter waits for the
  // filtered clock line, so a slave that holds the clock low stalls the master.
  // No arbitration is done: the master never checks the data line it drives.
  assign bit_rx = tw_is_rx(cmd, idx); // RL1
  assign bit_val = (cmd == tw_pkg::TW_OP_ADDR || cmd == tw_pkg::TW_OP_WRITE)
                   ? data[3'h7 - idx[2:0]] : data[`TW_DATA_MACK]; // RL16 RL17 RL18 RL19
  assign last_bit = (idx == tw_nbits(cmd) - 4'h1);
  // Quarter two is the clock-high quarter: it ends only once the filtered clock
  // line is seen high, which is how a slave holding the clock low stalls us.
  assign adv = tick & ((quarter != 2'h2) | scl_f);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= tw_pkg::TW_IDLE;
      busy <= 1'b0;
      cmd <= tw_pkg::TW_OP_STOP;
      quarter <= 2'h0;
      idx <= 4'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (soft_rst || !en) begin
      // An abort releases both lines at once and may leave the bus mid-frame;
      // software follows it with a stop when a slave could still be addressed.
      state <= tw_pkg::TW_IDLE; // RL5 RL14
      busy <= 1'b0;
      quarter <= 2'h0;
      idx <= 4'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (start_cmd) begin
      busy <= 1'b1; // RL23
      cmd <= new_cmd;
      quarter <= 2'h0;
      idx <= 4'h0;
      unique case (new_cmd)
        tw_pkg::TW_OP_ADDR: state <= tw_pkg::TW_START; // RL16
        tw_pkg::TW_OP_STOP: state <= tw_pkg::TW_STOP; // RL22
        default: state <= tw_pkg::TW_BIT; // RL17 RL18 RL19 RL21
      endcase
    end else if (adv) begin
      quarter <= quarter + 2'h1;
      unique case (state)
        tw_pkg::TW_IDLE: begin
          quarter <= 2'h0;
        end
        tw_pkg::TW_START: begin
          // Works from idle and as a repeated start after a held-low clock.
          unique case (quarter)
            2'h0: sda_low <= 1'b0;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b1;
            2'h3: begin
              scl_low <= 1'b1;
              state <= tw_pkg::TW_BIT;
            end
          endcase
        end
        tw_pkg::TW_BIT: begin
          // The data line moves only in quarter zero, with the clock low, so a data
          // bit can never be taken for a start or a stop.
          unique case (quarter)
            2'h0: sda_low <= ~bit_rx & ~bit_val;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= sda_low;
            2'h3: begin
              scl_low <= 1'b1;
              if (last_bit) begin
                state <= tw_pkg::TW_IDLE;
                busy <= 1'b0; // RL23
                idx <= 4'h0;
              end else begin
                idx <= idx + 4'h1;
              end
            end
          endcase
        end
        tw_pkg::TW_STOP: begin
          // Both lines are pulled low first, so the data line can then rise while
          // the clock is high, which is the stop.
          unique case (quarter)
            2'h0: begin
              scl_low <= 1'b1;
              sda_low <= 1'b1;
            end
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b0; // RL22
            2'h3: begin
              state <= tw_pkg::TW_IDLE;
              busy <= 1'b0; // RL23
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data register: software loads it only while idle, the sequencer fills it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data <= `TW_DATA_RESET;
    end else if (wr_data && !busy) begin
      data <= hwdata[7:0]; // RL15
    end else if (adv && state == tw_pkg::TW_BIT && quarter == 2'h2 && bit_rx) begin
      // Taken at the end of the clock-high quarter, after the slave has had the
      // whole low half of the bit to settle the data line.
      if (cmd == tw_pkg::TW_OP_ADDR || cmd == tw_pkg::TW_OP_WRITE) begin
        data[`TW_DATA_SACK] <= sda_f; // RL15 RL16 RL17
      end else begin
        data <= {data[6:0], sda_f}; // RL18 RL21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins: open-drain, so the output value is always low and only the enable moves.
  // The enables are registered and lag the sequencer by a cycle; the input filter
  // delay is far shorter than a quarter, so the lag never costs a bit.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pair0_out <= '0;
      pair1_out <= '0;
      pair0_oe <= '0;
      pair1_oe <= '0;
      pair0_owned <= 1'b0;
      pair1_owned <= 1'b0;
    end else begin
      pair0_out <= '0; // RL7
      pair1_out <= '0; // RL7
      pair0_oe.scl <= en & act0 & scl_low; // RL4 RL12
      pair0_oe.sda <= en & act0 & sda_low; // RL4 RL12
      pair1_oe.scl <= en & act1 & scl_low; // RL4 RL11
      pair1_oe.sda <= en & act1 & sda_low; // RL4 RL11
      pair0_owned <= act0; // RL7 RL12
      pair1_owned <= act1; // RL7 RL11 RL13
    end
  end
endmodule : tw_master

/* File: verification/tw_master_assertions.sv */
// Port checker for the two-wire master.
`timescale 1ns/1ps
module tw_master_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire tw_pkg::tw_pair_t pair0_in,
  input wire tw_pkg::tw_pair_t pair0_out,
  input wire tw_pkg::tw_pair_t pair0_oe,
  input wire logic pair0_owned,
  input wire tw_pkg::tw_pair_t pair1_in,
  input wire tw_pkg::tw_pair_t pair1_out,
  input wire tw_pkg::tw_pair_t pair1_oe,
  input wire logic pair1_owned
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic wr_ph;
  logic [31:0] wr_a;
  logic req;
  assign req = hready && hsel && htrans[1] && hsize == 3'h2;
  // The write data arrives a cycle after its address, so the address is held.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ph <= 1'b0;
      wr_a <= 32'h0;
    end else if (hready) begin
      wr_ph <= req && hwrite;
      wr_a <= haddr;
    end
  end
  ////////////////////////////////////////
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("Response is not OKAY.");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("Read data upper bits not zero.");
  read_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong.");
  write_nowait_a: assert property (req && hwrite |=> hreadyout)
    else $error("Write was stalled.");
  open_drain_a: assert property (pair0_out == 2'h0 && pair1_out == 2'h0)
    else $error("A bus pin was driven high.");
  one_pair_a: assert property (!(pair0_owned && pair1_owned))
    else $error("Both pairs routed.");
  unowned_quiet_a: assert property (!pair1_owned [*2] |-> pair1_oe == 2'h0)
    else $error("Unrouted pair pulled.");
  disable_free_a: assert property (wr_ph && hready && wr_a == 32'h30 && !hwdata[2]
    |-> ##[1:3] (pair0_oe == 2'h0 && pair1_oe == 2'h0))
    else $error("Disable left a line pulled.");
  reset_free_a: assert property (wr_ph && hready && wr_a == 32'h2C && hwdata[1]
    |-> ##[1:3] (pair0_oe == 2'h0 && pair1_oe == 2'h0))
    else $error("Software reset left a line pulled.");
  cover property (req && !hwrite);
  cover property (pair1_owned);
  cover property ($rose(pair0_oe.sda) && !pair0_oe.scl);
endmodule : tw_master_assertions
bind tw_master tw_master_assertions tw_master_assertions_inst (
  .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pair0_in(pair0_in),
  .pair0_out(pair0_out), .pair0_oe(pair0_oe), .pair0_owned(pair0_owned),
  .pair1_in(pair1_in), .pair1_out(pair1_out), .pair1_oe(pair1_oe),
  .pair1_owned(pair1_owned));

/* File: verification/tw_slave_model.sv */
// Behavioural bus slave that acknowledges one address and can stretch the clock.
`timescale 1ns/1ps
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  input wire logic slow,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int cnt = -1;
  logic [7:0] sh = 8'h00;
  logic in_addr = 1'b0;
  logic hit = 1'b0;
  logic rd = 1'b0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      cnt = -1;
      in_addr = 1'b1;
      hit = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      hit = 1'b0;
      in_addr = 1'b0;
    end
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    if (cnt == 7 && in_addr) begin
      hit = sh[7:1] == ADDR;
      rd = sh[0];
    end else if (cnt == 7 && hit && !rd) begin
      rx_byte = sh;
    end else if (cnt == 8) begin
      in_addr = 1'b0;
      // A not-acknowledge from the master ends our read data.
      if (rd && sda) hit = 1'b0;
    end
  end
  always @(negedge scl) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    sda_pull = hit && ((cnt == 8 && (!rd || in_addr)) ||
      (cnt < 8 && rd && !in_addr && !tx_byte[7 - cnt]));
    // Stretching far beyond a quarter forces the master to wait on the line.
    if (slow) begin
      scl_pull = 1'b1;
      #4000;
      scl_pull = 1'b0;
    end
  end
endmodule : tw_slave_model

/* File: verification/tw_master_tb.sv */
// Self-checking bench for the two-wire master.
`timescale 1ns/1ps
module tw_master_tb;
  localparam logic [6:0] SLV = 7'h2A;
  localparam logic [7:0] TXB = 8'hC5;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pair0_owned, pair1_owned, s_scl, s_sda;
  logic slow = 1'b0;
  logic [31:0] hrdata, rd;
  logic [7:0] rx_byte;
  tw_pkg::tw_pair_t pair0_in, pair0_out, pair0_oe, pair1_in, pair1_out, pair1_oe;
  int mismatches = 0;
  int compares = 0;
  // Both pairs have pull-ups; only pair zero has a slave on it.
  assign pair0_in = {!pair0_oe.scl && !s_scl, !pair0_oe.sda && !s_sda};
  assign pair1_in = {!pair1_oe.scl, !pair1_oe.sda};
  tw_master tw_master_inst (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pair0_in(pair0_in),
    .pair0_out(pair0_out), .pair0_oe(pair0_oe), .pair0_owned(pair0_owned),
    .pair1_in(pair1_in), .pair1_out(pair1_out), .pair1_oe(pair1_oe),
    .pair1_owned(pair1_owned));
  tw_slave_model #(.ADDR(SLV)) tw_slave_model_inst (
    .scl(pair0_in.scl), .sda(pair0_in.sda), .tx_byte(TXB), .slow(slow),
    .scl_pull(s_scl), .sda_pull(s_sda), .rx_byte(rx_byte));
  initial forever #5 mclk = ~mclk;
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task cmd(input logic [7:0] c, input logic [7:0] e);
    bus(1'b1, 32'h2C, {24'h0, c});
    bus(1'b0, 32'h2C, 32'h0);
    chk(rd, 32'hFF);
    while (rd[0] !== 1'b0) bus(1'b0, 32'h2C, 32'h0);
    bus(1'b0, 32'h28, 32'h0);
    chk(rd, {24'h0, e});
  endtask : cmd
  task t_regs;
    bus(1'b0, 32'h28, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h2C, 32'h0);
    chk(rd, 32'hFE);
    bus(1'b0, 32'h30, 32'h0);
    chk(rd, 32'h40);
    bus(1'b0, 32'h34, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 32'h30, 32'hB3);
    bus(1'b0, 32'h30, 32'h0);
    chk(rd, 32'hF3);
    bus(1'b1, 32'h2C, 32'h0);
    bus(1'b0, 32'h2C, 32'h0);
    chk(rd, 32'hFE);
    chk({28'h0, pair0_in, pair1_in}, 32'hF);
    bus(1'b1, 32'h30, 32'h37);
    repeat (3) @(posedge mclk);
    chk({30'h0, pair0_owned, pair1_owned}, 32'h2);
    bus(1'b1, 32'h2C, 32'h42);
    bus(1'b0, 32'h2C, 32'h0);
    chk(rd, 32'hFE);
    $display("t_regs done");
  endtask : t_regs
  task t_write;
    bus(1'b1, 32'h30, 32'h17);
    bus(1'b1, 32'h28, {24'h0, SLV, 1'b0});
    chk({31'h0, pair0_owned}, 32'h1);
    cmd(8'h00, {SLV, 1'b0});
    bus(1'b1, 32'h28, 32'h5A);
    cmd(8'h10, 8'h5A);
    cmd(8'h70, 8'h5A);
    chk({24'h0, rx_byte}, 32'h5A);
    chk({30'h0, pair0_in}, 32'h3);
    $display("t_write done");
  endtask : t_write
  task t_read;
    slow <= 1'b1;
    bus(1'b1, 32'h28, {24'h0, SLV, 1'b1});
    cmd(8'h00, {SLV, 1'b0});
    cmd(8'h60, TXB);
    bus(1'b1, 32'h28, 32'h0);
    cmd(8'h20, TXB);
    bus(1'b1, 32'h28, 32'h80);
    cmd(8'h30, 8'h80);
    cmd(8'h70, 8'h80);
    slow <= 1'b0;
    chk({30'h0, pair0_in}, 32'h3);
    $display("t_read done");
  endtask : t_read
  task t_nak;
    bus(1'b1, 32'h30, 32'h27);
    bus(1'b1, 32'h28, {24'h0, SLV, 1'b0});
    cmd(8'h00, {SLV, 1'b1});
    chk({30'h0, pair1_in}, 32'h1);
    bus(1'b1, 32'h2C, 32'h02);
    repeat (4) @(posedge mclk);
    chk({30'h0, pair1_in}, 32'h3);
    $display("t_nak done");
  endtask : t_nak
  task t_speed;
    int q[5];
    int n;
    longint t;
    // A stop is four quarters long, so its busy time shows the rate.
    q = '{2500, 500, 250, 75, 150};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 32'h30, (i == 4) ? 32'h97 : 32'h14 + i);
      t = $time;
      bus(1'b1, 32'h2C, 32'h70);
      rd = 32'h1;
      while (rd[0] !== 1'b0) bus(1'b0, 32'h2C, 32'h0);
      n = int'(($time - t) / 10);
      chk({31'h0, n >= 4 * q[i] && n <= 4 * q[i] + 40}, 32'h1);
    end
    $display("t_speed done");
  endtask : t_speed
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #900000;
    mismatches++;
    $display("Error at %0t: timeout", $time);
    finish_test;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_regs;
    t_write;
    t_read;
    t_nak;
    t_speed;
    finish_test;
  end
endmodule : tw_master_tb
